// >>> rtl/tagged_alu_pkg.sv
// Constants, types and decode helpers for the tagged arithmetic datapath
package tagged_alu_pkg;

    // Instruction field positions
    localparam int OP_HI = 31;
    localparam int OP_LO = 30;
    localparam int RD_HI = 29;
    localparam int RD_LO = 25;
    localparam int OPX_HI = 24;
    localparam int OPX_LO = 19;
    localparam int SA_HI = 18;
    localparam int SA_LO = 14;
    localparam int IMM_SEL = 13;
    localparam int IMM_HI = 12;
    localparam int SB_HI = 4;
    localparam int SB_LO = 0;

    localparam logic [1:0] FMT3_ARITH = 2'h2;
    localparam logic [5:0] OPX_TADD_TV = 6'h22;
    localparam logic [5:0] OPX_TSUB_TV = 6'h23;
    localparam logic [5:0] OPX_WRITE_Y = 6'h30;
    localparam logic [4:0] RD_Y_SEL = 5'h00;

    // Register word addresses on the Avalon-MM slave
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_CLEAR = 3'h1;
    localparam logic [2:0] REG_ENABLE = 3'h2;
    localparam logic [2:0] REG_CTRL = 3'h3;
    localparam logic [2:0] REG_YVAL = 3'h4;

    // Event bits of status, clear and enable, their count, and the exec enable bit of ctrl
    localparam int EV_TRAP = 0;
    localparam int EV_TAGGED_OK = 1;
    localparam int EV_Y_WRITE = 2;
    localparam int EV_W = 3;
    localparam int CTRL_EXEC_EN = 0;

    // Condition code layout: xcc in the high nibble, icc in the low
    localparam int ICC_C = 0;
    localparam int ICC_V = 1;
    localparam int ICC_Z = 2;
    localparam int ICC_N = 3;
    localparam int XCC_C = 4;
    localparam int XCC_V = 5;
    localparam int XCC_Z = 6;
    localparam int XCC_N = 7;

    localparam logic [31:0] Y_RESET = 32'h0000_0000;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    localparam logic CTRL_RESET = 1'h1;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_TADD = 2'b01,
        OP_TSUB = 2'b10,
        OP_YWR = 2'b11
    } opsel_e;

    function automatic opsel_e decodeOp(input logic [31:0] instr, input logic valid);
        logic [5:0] opx;
        opx = instr[OPX_HI:OPX_LO];
        decodeOp = OP_NONE;
        if (valid && instr[OP_HI:OP_LO] == FMT3_ARITH) begin
            if (opx == OPX_TADD_TV) begin
                decodeOp = OP_TADD;
            end else if (opx == OPX_TSUB_TV) begin
                decodeOp = OP_TSUB;
            end else if (opx == OPX_WRITE_Y && instr[RD_HI:RD_LO] == RD_Y_SEL) begin
                decodeOp = OP_YWR;
            end
        end
    endfunction

    function automatic logic [63:0] secondOperand(input logic [31:0] instr,
                                                  input logic [63:0] srcB);
        if (instr[IMM_SEL]) begin
            secondOperand = {{51{instr[IMM_HI]}}, instr[IMM_HI:0]};
        end else begin
            secondOperand = srcB;
        end
    endfunction

endpackage

// >>> rtl/tagged_alu_core.sv
// Adder, subtractor, xor and condition code logic for the tagged ops
`timescale 1ns/100ps
`default_nettype none
module tagged_alu_core (
    input wire tagged_alu_pkg::opsel_e opSel,
    input wire logic [63:0] opA,
    input wire logic [63:0] opB,
    output logic [63:0] result,
    output logic [7:0] ccr,
    output logic tagOverflow
);
    logic [64:0] wide;
    logic [32:0] low;
    logic v32;
    logic v64;
    logic tagBits;

    always_comb begin
        wide = '0;
        low = '0;
        v32 = 1'b0;
        v64 = 1'b0;
        result = opA ^ opB;
        tagBits = (|opA[1:0]) | (|opB[1:0]);
        tagOverflow = 1'b0;
        unique case (opSel)
            tagged_alu_pkg::OP_TADD: begin
                wide = {1'b0, opA} + {1'b0, opB};
                low = {1'b0, opA[31:0]} + {1'b0, opB[31:0]};
                v32 = (opA[31] == opB[31]) && (low[31] != opA[31]);
                v64 = (opA[63] == opB[63]) && (wide[63] != opA[63]);
                result = wide[63:0];
                tagOverflow = tagBits | v32;
            end
            tagged_alu_pkg::OP_TSUB: begin
                // Borrow falls out of the extra top bit
                wide = {1'b0, opA} - {1'b0, opB};
                low = {1'b0, opA[31:0]} - {1'b0, opB[31:0]};
                v32 = (opA[31] != opB[31]) && (low[31] != opA[31]);
                v64 = (opA[63] != opB[63]) && (wide[63] != opA[63]);
                result = wide[63:0];
                tagOverflow = tagBits | v32;
            end
            tagged_alu_pkg::OP_YWR, tagged_alu_pkg::OP_NONE: begin
            end
        endcase
        ccr[tagged_alu_pkg::XCC_N] = result[63];
        ccr[tagged_alu_pkg::XCC_Z] = (result == 64'h0);
        ccr[tagged_alu_pkg::XCC_V] = v64;
        ccr[tagged_alu_pkg::XCC_C] = wide[64];
        ccr[tagged_alu_pkg::ICC_N] = result[31];
        ccr[tagged_alu_pkg::ICC_Z] = (result[31:0] == 32'h0);
        // Only reaches writeback without a trap, so always clear
        ccr[tagged_alu_pkg::ICC_V] = 1'b0;
        ccr[tagged_alu_pkg::ICC_C] = low[32];
    end
endmodule
`default_nettype wire

// >>> rtl/tagged_arith_y_write.sv
// Tagged add/subtract with trap, Y write, and Avalon-MM status registers
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module tagged_arith_y_write (
    input wire logic clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire logic [31:0] instr,
    input wire logic [63:0] srcAValue,
    input wire logic [63:0] srcBValue,
    output logic rdWriteEn,
    output logic [4:0] rdIndex,
    output logic [63:0] rdData,
    output logic ccrWriteEn,
    output logic [7:0] ccrValue,
    output logic tagTrap,
    output logic [31:0] yValue,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    typedef struct packed {
        logic rdWriteEn;
        logic [4:0] rdIndex;
        logic [63:0] rdData;
        logic ccrWriteEn;
        logic [7:0] ccrValue;
        logic tagTrap;
        logic [31:0] yReg;
        logic [2:0] status;
        logic [2:0] enable;
        logic execEn;
        logic waitReq;
        logic [31:0] readData;
        logic irq;
    } state_s;

    state_s stReg;
    state_s stNext;
    tagged_alu_pkg::opsel_e opSel;
    logic [63:0] operandB;
    logic [63:0] aluResult;
    logic [7:0] aluCcr;
    logic tagOvf;
    logic busReq;
    logic busCommit;
    logic [2:0] evSet;
    logic [2:0] clearMask;

    assign opSel = tagged_alu_pkg::decodeOp(instr, issueValid && stReg.execEn);
    assign operandB = tagged_alu_pkg::secondOperand(instr, srcBValue);

    tagged_alu_core core (
        .opSel(opSel),
        .opA(srcAValue),
        .opB(operandB),
        .result(aluResult),
        .ccr(aluCcr),
        .tagOverflow(tagOvf)
    );

    assign busReq = avs_read || avs_write;
    // Second cycle of a request: the master sees waitrequest low here
    assign busCommit = busReq && !stReg.waitReq;

    always_comb begin
        stNext = stReg;
        stNext.rdWriteEn = 1'b0;
        stNext.ccrWriteEn = 1'b0;
        stNext.tagTrap = 1'b0;
        evSet = '0;
        clearMask = '0;
        unique case (opSel)
            tagged_alu_pkg::OP_TADD, tagged_alu_pkg::OP_TSUB: begin
                if (tagOvf) begin
                    stNext.tagTrap = 1'b1;
                    evSet[tagged_alu_pkg::EV_TRAP] = 1'b1;
                end else begin
                    stNext.rdWriteEn = 1'b1;
                    stNext.rdIndex = instr[tagged_alu_pkg::RD_HI:tagged_alu_pkg::RD_LO];
                    stNext.rdData = aluResult;
                    stNext.ccrWriteEn = 1'b1;
                    stNext.ccrValue = aluCcr;
                    evSet[tagged_alu_pkg::EV_TAGGED_OK] = 1'b1;
                end
            end
            tagged_alu_pkg::OP_YWR: begin
                // xor into Y, seen next cycle
                stNext.yReg = aluResult[31:0];
                evSet[tagged_alu_pkg::EV_Y_WRITE] = 1'b1;
            end
            tagged_alu_pkg::OP_NONE: begin
            end
        endcase

        // One wait cycle, then the answer stands for one cycle
        stNext.waitReq = !(busReq && stReg.waitReq);
        if (busReq && stReg.waitReq && avs_read) begin
            unique case (avs_address)
                tagged_alu_pkg::REG_STATUS: stNext.readData = {29'h0, stReg.status};
                tagged_alu_pkg::REG_ENABLE: stNext.readData = {29'h0, stReg.enable};
                tagged_alu_pkg::REG_CTRL: stNext.readData = {31'h0, stReg.execEn};
                tagged_alu_pkg::REG_YVAL: stNext.readData = stReg.yReg;
                default: stNext.readData = 32'h0;
            endcase
        end
        if (busCommit && avs_write) begin
            unique case (avs_address)
                tagged_alu_pkg::REG_CLEAR: clearMask = avs_writedata[2:0];
                tagged_alu_pkg::REG_ENABLE: stNext.enable = avs_writedata[2:0];
                tagged_alu_pkg::REG_CTRL: stNext.execEn = avs_writedata[tagged_alu_pkg::CTRL_EXEC_EN];
                default: begin
                end
            endcase
        end
        // Set beats a simultaneous clear so no event is lost
        stNext.status = (stReg.status & ~clearMask) | evSet;
        stNext.irq = |(stNext.status & stNext.enable);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stReg <= '{
                rdWriteEn: 1'b0,
                rdIndex: 5'h00,
                rdData: 64'h0,
                ccrWriteEn: 1'b0,
                ccrValue: 8'h00,
                tagTrap: 1'b0,
                yReg: tagged_alu_pkg::Y_RESET,
                status: 3'h0,
                enable: tagged_alu_pkg::ENABLE_RESET,
                execEn: tagged_alu_pkg::CTRL_RESET,
                waitReq: 1'b1,
                readData: 32'h0,
                irq: 1'b0
            };
        end else begin
            stReg <= stNext;
        end
    end

    assign rdWriteEn = stReg.rdWriteEn;
    assign rdIndex = stReg.rdIndex;
    assign rdData = stReg.rdData;
    assign ccrWriteEn = stReg.ccrWriteEn;
    assign ccrValue = stReg.ccrValue;
    assign tagTrap = stReg.tagTrap;
    assign yValue = stReg.yReg;
    assign avs_readdata = stReg.readData;
    assign avs_waitrequest = stReg.waitReq;
    assign irq = stReg.irq;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [63:0] chkB;
    logic isTadd;
    logic isTsub;
    logic tagLow;
    logic [64:0] chkSum;
    logic [64:0] chkDiff;
    logic chkAddV32;
    logic chkSubV32;
    assign chkB = instr[13] ? {{51{instr[12]}}, instr[12:0]} : srcBValue;
    assign isTadd = issueValid && stReg.execEn && instr[31:30] == 2'h2 && instr[24:19] == 6'h22;
    assign isTsub = issueValid && stReg.execEn && instr[31:30] == 2'h2 && instr[24:19] == 6'h23;
    assign tagLow = (|srcAValue[1:0]) || (|chkB[1:0]);
    assign chkSum = {1'b0, srcAValue} + {1'b0, chkB};
    assign chkDiff = {1'b0, srcAValue} - {1'b0, chkB};
    assign chkAddV32 = srcAValue[31] == chkB[31] && chkSum[31] != srcAValue[31];
    assign chkSubV32 = srcAValue[31] != chkB[31] && chkDiff[31] != srcAValue[31];
    logic isYw;
    logic anyTaken;
    assign isYw = issueValid && stReg.execEn && instr[31:30] == 2'h2 && instr[24:19] == 6'h30 &&
        instr[29:25] == 5'h00;
    assign anyTaken = isTadd || isTsub || isYw;

    sequence s_addTrapCause;
        isTadd && (tagLow || chkAddV32);
    endsequence

    sequence s_subTrapCause;
        isTsub && (tagLow || chkSubV32);
    endsequence

    sequence s_trapOnly;
        tagTrap && !rdWriteEn && !ccrWriteEn;
    endsequence

    property p_addTrap;
        s_addTrapCause |=> s_trapOnly;
    endproperty
    a_addTrap: assert property (p_addTrap) else $error("tagged add overflow not trapped");

    property p_subTrap;
        s_subTrapCause |=> s_trapOnly;
    endproperty
    a_subTrap: assert property (p_subTrap) else $error("tagged sub overflow not trapped");

    property p_trapHoldsState;
        tagTrap |-> $stable(yValue) && !rdWriteEn && !ccrWriteEn;
    endproperty
    a_trapHoldsState: assert property (p_trapHoldsState) else $error("trap with writeback");

    property p_addWrite;
        isTadd && !tagLow && !chkAddV32 |=>
            rdWriteEn && ccrWriteEn && !tagTrap && rdData == $past(chkSum[63:0]);
    endproperty
    a_addWrite: assert property (p_addWrite) else $error("tagged add sum not written");

    property p_subWrite;
        isTsub && !tagLow && !chkSubV32 |=>
            rdWriteEn && !tagTrap && rdData == $past(chkDiff[63:0]);
    endproperty
    a_subWrite: assert property (p_subWrite) else $error("tagged sub result not written");

    property p_addXcc;
        isTadd && !tagLow && !chkAddV32 |=>
            ccrValue[5] == ($past(srcAValue[63]) == $past(chkB[63]) &&
                $past(chkSum[63]) != $past(srcAValue[63])) && ccrValue[4] == $past(chkSum[64]);
    endproperty
    a_addXcc: assert property (p_addXcc) else $error("tagged add xcc wrong");

    property p_subCarry;
        isTsub && !tagLow && !chkSubV32 |=>
            ccrValue[4] == $past(chkDiff[64]) && ccrValue[6] == ($past(chkDiff[63:0]) == 64'h0);
    endproperty
    a_subCarry: assert property (p_subCarry) else $error("tagged sub xcc wrong");

    property p_iccVClear;
        ccrWriteEn |-> !ccrValue[1];
    endproperty
    a_iccVClear: assert property (p_iccVClear) else $error("icc.v set on tagged op");

    property p_yWrite;
        issueValid && stReg.execEn && instr[31:30] == 2'h2 && instr[24:19] == 6'h30 &&
            instr[29:25] == 5'h00 |=> yValue == $past(srcAValue[31:0] ^ chkB[31:0]);
    endproperty
    a_yWrite: assert property (p_yWrite) else $error("Y not written with xor");

    sequence s_busAnswer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_busAnswer;
        busReq && avs_waitrequest |=> s_busAnswer;
    endproperty
    a_busAnswer: assert property (p_busAnswer) else $error("bus answer not one cycle late");

    property p_setWins;
        busCommit && avs_write && avs_address == 3'h1 && avs_writedata[0] && isTadd && tagLow
            |=> stReg.status[0];
    endproperty
    a_setWins: assert property (p_setWins) else $error("trap event lost");

    property p_ignored;
        !anyTaken |=> !rdWriteEn && !ccrWriteEn && !tagTrap && $stable(yValue);
    endproperty
    a_ignored: assert property (p_ignored) else $error("output for an ignored word");

    property p_addImm;
        isTadd && instr[13] && !tagLow && !chkAddV32 |=>
            rdData == $past(srcAValue + {{51{instr[12]}}, instr[12:0]});
    endproperty
    a_addImm: assert property (p_addImm) else $error("immediate operand wrong");

    property p_trapKeeps;
        tagTrap |-> $stable(rdData) && $stable(rdIndex) && $stable(ccrValue);
    endproperty
    a_trapKeeps: assert property (p_trapKeeps) else $error("trap changed result");

    property p_addIcc;
        isTadd && !tagLow && !chkAddV32 |=> ccrValue[7] == $past(chkSum[63]) &&
            ccrValue[3] == $past(chkSum[31]) && ccrValue[2] == ($past(chkSum[31:0]) == 32'h0);
    endproperty
    a_addIcc: assert property (p_addIcc) else $error("tagged add n or z wrong");

    property p_subIcc;
        isTsub && !tagLow && !chkSubV32 |=> ccrValue[7] == $past(chkDiff[63]) &&
            ccrValue[3] == $past(chkDiff[31]) && ccrValue[2] == ($past(chkDiff[31:0]) == 32'h0);
    endproperty
    a_subIcc: assert property (p_subIcc) else $error("tagged sub n or z wrong");

    property p_subXccV;
        isTsub && !tagLow && !chkSubV32 |=>
            ccrValue[5] == ($past(srcAValue[63]) != $past(chkB[63]) &&
                $past(chkDiff[63]) != $past(srcAValue[63]));
    endproperty
    a_subXccV: assert property (p_subXccV) else $error("tagged sub xcc.v wrong");

    property p_irqLevel;
        irq == |(stReg.status & stReg.enable);
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("irq disagrees with status");

    property p_statusSticky;
        stReg.status[0] && !(busCommit && avs_write && avs_address == 3'h1 && avs_writedata[0])
            |=> stReg.status[0];
    endproperty
    a_statusSticky: assert property (p_statusSticky) else $error("trap status not sticky");

    property p_waitIdle;
        !busReq |=> avs_waitrequest;
    endproperty
    a_waitIdle: assert property (p_waitIdle) else $error("waitrequest low while idle");

    property p_readStatus;
        busReq && avs_waitrequest && avs_read && avs_address == 3'h0 |=>
            avs_readdata == {29'h0, $past(stReg.status)};
    endproperty
    a_readStatus: assert property (p_readStatus) else $error("status read data wrong");

endmodule
`default_nettype wire

// >>> testbench/pipe_partner.sv
// Register file and condition code holder standing in for the pipeline
`timescale 1ns/100ps
`default_nettype none
module pipe_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] instr,
    output logic [63:0] srcAValue,
    output logic [63:0] srcBValue,
    input wire logic rdWriteEn,
    input wire logic [4:0] rdIndex,
    input wire logic [63:0] rdData,
    input wire logic ccrWriteEn,
    input wire logic [7:0] ccrValue
);
    // Preloaded by the bench; never reset, like a real register file
    logic [63:0] regs [32];
    logic [7:0] ccr;

    assign srcAValue = regs[instr[tagged_alu_pkg::SA_HI:tagged_alu_pkg::SA_LO]];
    assign srcBValue = regs[instr[tagged_alu_pkg::SB_HI:tagged_alu_pkg::SB_LO]];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ccr <= 8'h00;
        end else begin
            if (rdWriteEn && rdIndex != 5'h00) begin
                regs[rdIndex] <= rdData;
            end
            if (ccrWriteEn) begin
                ccr <= ccrValue;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tagged_arith_and_y_write_bench.sv
// Self-checking bench for the tagged arithmetic and Y write block
`timescale 1ns/100ps
`default_nettype none
module tagged_arith_and_y_write_bench;
    typedef struct packed {
        logic [5:0] opx;
        logic [4:0] rd;
        logic immSel;
        logic [12:0] imm;
        logic [63:0] a;
        logic [63:0] b;
        logic trapExp;
    } row_s;
    localparam logic [5:0] ADD = tagged_alu_pkg::OPX_TADD_TV;
    localparam logic [5:0] SUB = tagged_alu_pkg::OPX_TSUB_TV;
    localparam logic [5:0] YW = tagged_alu_pkg::OPX_WRITE_Y;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issueValid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [63:0] srcAValue, srcBValue, rdData, resE, bOp, rdOld;
    logic [31:0] yValue, avs_readdata, rdv, yExp;
    logic [7:0] ccrValue, ccE, ccOld;
    logic [4:0] rdIndex;
    logic rdWriteEn, ccrWriteEn, tagTrap, avs_waitrequest, irq, isA, isY, okA;
    int n_fail = 0;
    int n_compared = 0;
    row_s rows [$];
    row_s r;

    always #2.5 clk = !clk;

    tagged_arith_y_write uut (.clk, .rst, .issueValid, .instr, .srcAValue, .srcBValue,
        .rdWriteEn, .rdIndex, .rdData, .ccrWriteEn, .ccrValue, .tagTrap, .yValue,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .irq);
    pipe_partner partner (.clk, .rst, .instr, .srcAValue, .srcBValue, .rdWriteEn,
        .rdIndex, .rdData, .ccrWriteEn, .ccrValue);

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Master holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= adr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 40) begin
            n_fail++;
            print_verdict();
        end
    endtask

    task automatic rdchk(input logic [2:0] adr, input logic [31:0] exp, input string what);
        bus(1'b0, adr, 32'h0);
        chk(what, rdv, exp);
    endtask

    // Leaves the caller just after the edge where the answer shows
    task automatic issue(input logic [31:0] word);
        @(posedge clk);
        instr <= word;
        issueValid <= 1'b1;
        @(posedge clk);
        issueValid <= 1'b0;
        #1;
    endtask

    function automatic void arith(input logic sub, input logic [63:0] a,
                                  input logic [63:0] b, output logic [63:0] res,
                                  output logic [7:0] cc);
        logic [64:0] s;
        logic [32:0] s32;
        logic v64;
        s = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        s32 = sub ? {1'b0, a[31:0]} - {1'b0, b[31:0]} : {1'b0, a[31:0]} + {1'b0, b[31:0]};
        v64 = (a[63] ^ s[63]) & ((a[63] ^ b[63]) == sub);
        res = s[63:0];
        cc = {s[63], s[63:0] == 64'h0, v64, s[64], s[31], s[31:0] == 32'h0, 1'b0, s32[32]};
    endfunction

    initial begin
        rows.push_back('{ADD, 5'h03, 1'b0, 13'h0, 64'h4, 64'h8, 1'b0});
        rows.push_back('{ADD, 5'h03, 1'b0, 13'h0, 64'h1, 64'h8, 1'b1});
        rows.push_back('{ADD, 5'h03, 1'b0, 13'h0, 64'h4, 64'h2, 1'b1});
        rows.push_back('{ADD, 5'h03, 1'b0, 13'h0, 64'h7fff_fffc, 64'h4, 1'b1});
        rows.push_back('{ADD, 5'h03, 1'b1, 13'h1ffc, 64'h8, 64'h0, 1'b0});
        rows.push_back('{ADD, 5'h03, 1'b0, 13'h0, 64'h7fff_ffff_0000_0000,
                         64'h7fff_ffff_0000_0000, 1'b0});
        rows.push_back('{SUB, 5'h03, 1'b0, 13'h0, 64'h8, 64'h4, 1'b0});
        rows.push_back('{SUB, 5'h03, 1'b0, 13'h0, 64'h4, 64'h8, 1'b0});
        rows.push_back('{SUB, 5'h03, 1'b0, 13'h0, 64'h8000_0000, 64'h4, 1'b1});
        rows.push_back('{SUB, 5'h03, 1'b1, 13'h0004, 64'h0, 64'h0, 1'b0});
        rows.push_back('{SUB, 5'h03, 1'b0, 13'h0, 64'h10, 64'h5, 1'b1});
        rows.push_back('{YW, 5'h00, 1'b0, 13'h0, 64'h1234_5678_9abc_def0,
                         64'hffff_0000_ffff_0000, 1'b0});
        rows.push_back('{YW, 5'h00, 1'b1, 13'h1000, 64'h0f0f, 64'h0, 1'b0});
        rows.push_back('{YW, 5'h05, 1'b0, 13'h0, 64'h55, 64'haa, 1'b0});
        rows.push_back('{6'h20, 5'h03, 1'b0, 13'h0, 64'h4, 64'h8, 1'b0});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[n]) begin
            r = rows[n];
            partner.regs[1] = r.a;
            partner.regs[2] = r.b;
            bOp = r.immSel ? {{51{r.imm[12]}}, r.imm} : r.b;
            arith(r.opx[0], r.a, bOp, resE, ccE);
            isA = (r.opx == ADD || r.opx == SUB);
            isY = (r.opx == YW && r.rd == 5'h00);
            okA = isA && !r.trapExp;
            ccOld = partner.ccr;
            rdOld = partner.regs[3];
            yExp = isY ? r.a[31:0] ^ bOp[31:0] : yValue;
            issue({2'b10, r.rd, r.opx, 5'h01, r.immSel, r.immSel ? r.imm : 13'h0002});
            chk("tagTrap", tagTrap, isA & r.trapExp); // trap flag
            chk("rdWriteEn", rdWriteEn, okA); // sum written
            chk("ccrWriteEn", ccrWriteEn, okA); // codes written
            if (okA) begin
                chk("rdData", rdData, resE); // operand choice
                chk("ccrValue", ccrValue, ccE); // plain codes
                chk("rdIndex", rdIndex, r.rd); // field decode
            end
            chk("yValue", yValue, yExp); // xor into Y
            @(posedge clk);
            #1;
            chk("held codes", partner.ccr, okA ? ccE : ccOld); // codes kept
            chk("held dest", partner.regs[3], okA ? resE : rdOld); // dest kept
        end
        $display("table test done");
        rdchk(tagged_alu_pkg::REG_STATUS, 32'h7, "status events");
        chk("irq masked", irq, 1'b0);
        bus(1'b1, tagged_alu_pkg::REG_ENABLE, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("irq raised", irq, 1'b1);
        bus(1'b1, tagged_alu_pkg::REG_CLEAR, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", irq, 1'b0);
        rdchk(tagged_alu_pkg::REG_STATUS, 32'h6, "status after clear");
        $display("interrupt test done");
        partner.regs[1] = 64'h4;
        bus(1'b1, tagged_alu_pkg::REG_CTRL, 32'h0);
        issue(32'h8718_4002);
        chk("refused write", rdWriteEn, 1'b0);
        bus(1'b1, tagged_alu_pkg::REG_CTRL, 32'h1);
        // Two Y writes back to back, each seen by the next cycle
        @(posedge clk);
        instr <= 32'h8180_6005;
        issueValid <= 1'b1;
        @(posedge clk);
        instr <= 32'h8180_6009;
        #1;
        chk("first Y", yValue, 32'h1); // visible one cycle after issue
        @(posedge clk);
        issueValid <= 1'b0;
        #1;
        chk("second Y", yValue, 32'hd); // visible one cycle after issue
        rdchk(tagged_alu_pkg::REG_YVAL, 32'hd, "Y readback");
        $display("back to back test done");
        // Trap taken at the very edge where a clear of the trap bit commits
        fork
            bus(1'b1, tagged_alu_pkg::REG_CLEAR, 32'h1);
            begin
                @(posedge clk);
                issue({2'b10, 5'h03, ADD, 5'h01, 1'b1, 13'h0001});
            end
        join
        chk("trap beside clear", tagTrap, 1'b1); // trap flag
        chk("irq beside clear", irq, 1'b1);
        rdchk(tagged_alu_pkg::REG_STATUS, 32'h7, "set beats clear");
        $display("set against clear test done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("reset Y", yValue, 32'h0);
        chk("reset irq", irq, 1'b0);
        chk("reset wait", avs_waitrequest, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, tagged_alu_pkg::REG_STATUS, 32'hffff_ffff);
        bus(1'b1, 3'h5, 32'hffff_ffff);
        rdchk(tagged_alu_pkg::REG_STATUS, 32'h0, "status reset");
        rdchk(tagged_alu_pkg::REG_ENABLE, 32'h0, "enable reset");
        rdchk(tagged_alu_pkg::REG_CTRL, 32'h1, "ctrl reset");
        rdchk(tagged_alu_pkg::REG_YVAL, 32'h0, "Y reset");
        rdchk(3'h5, 32'h0, "unmapped");
        $display("reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
